// ===== src/wdtf_pkg.sv
// Package: register map, field layout and reset values of the watchdog
package wdtf_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0]  CTRL_IDX      = 8'ha7;
   localparam logic [7:0]  MODE_IDX      = 8'ha8;
   localparam logic [7:0]  RELOAD_IDX    = 8'hc1;
   localparam logic [7:0]  FEED1_IDX     = 8'hc2;
   localparam logic [7:0]  FEED2_IDX     = 8'hc3;
   localparam int          ADDR_SHIFT    = 2;
   localparam int          IDX_W         = 8;

   // Feed constants
   localparam logic [7:0]  FEED1_KEY     = 8'ha5;
   localparam logic [7:0]  FEED2_KEY     = 8'h5a;

   // Timeout law: tap period is 2^(TAP_BASE+tap) watchdog clocks
   localparam logic [12:0] TAP_BASE_ONE  = 13'h0020;

   // Mode register field positions
   localparam int          MODE_IRQ_EN   = 0;
   localparam int          MODE_RST_EN   = 1;
   localparam int          MODE_SAFETY   = 2;

   // Control register layout
   typedef struct packed {
      logic [2:0] prescaler_tap_select;
      logic [1:0] reserved;
      logic       run_control_bit;
      logic       timeout_flag;
      logic       clock_source_select;
   } wdtf_ctrl_t;

   // Reset value of the control register: tap 7, running, oscillator
   localparam wdtf_ctrl_t CTRL_RESET = '{
      prescaler_tap_select : 3'h7,
      reserved             : 2'h0,
      run_control_bit      : 1'b1,
      timeout_flag         : 1'b0,
      clock_source_select  : 1'b1
   };
   localparam logic [7:0]  RELOAD_RESET  = 8'hff;

   // Feed sequence progress
   typedef enum logic [1:0] {
      FEED_IDLE,
      FEED_CTRL_WAIT,
      FEED_ARMED
   } wdtf_feed_t;

endpackage

// ===== src/wdtf_top.sv
// Watchdog timer with feed sequence, behind a classic Wishbone slave
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/10ps
module wdtf_top #(
   parameter int PRESC_W = 13,
   parameter int COUNT_W = 8
) (
   // Clock and power-on reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone classic slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [31:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // User configuration byte bits
   input  wire logic        cfg_reset_enable_i,
   input  wire logic        cfg_safety_enable_i,
   // Watchdog oscillator tick, other register writes, power state
   input  wire logic        wdosc_tick_i,
   input  wire logic        other_sfr_write_i,
   input  wire logic        power_down_i,
   input  wire logic        osc_stable_i,
   // System side
   output logic             wdt_reset_o,
   output logic             osc_restart_o,
   output logic             timeout_irq_o
);

   // Bus decode
   logic                 bus_req;
   logic                 bus_wr;
   logic [7:0]           bus_idx;
   logic                 idx_in_range;
   logic                 wr_lane0;
   logic [7:0]           wr_byte;
   // Configuration
   logic                 rst_en;
   logic                 safety_en;
   logic                 locked;
   logic                 cfg_loaded;
   // Shadow and active registers
   wdtf_pkg::wdtf_ctrl_t ctrl_shadow;
   wdtf_pkg::wdtf_ctrl_t ctrl_active;
   logic [COUNT_W-1:0]   reload_shadow;
   logic                 irq_enable;
   logic                 ctrl_written;
   logic                 reload_written;
   logic                 timeout_flag;
   // Feed tracking
   wdtf_pkg::wdtf_feed_t feed_state;
   logic                 feed_ok;
   logic                 feed_bad;
   logic                 ctrl_wr;
   logic                 reload_wr;
   // Counting
   logic                 pclk_phase;
   logic                 src_osc;
   logic                 wd_tick;
   logic [PRESC_W-1:0]   prescaler;
   logic [PRESC_W-1:0]   tap_mask;
   logic [COUNT_W-1:0]   counter;
   logic                 underflow_pend;
   logic                 underflow;
   logic                 eff_run;
   logic                 eff_osc;
   // Reset generation
   logic                 wd_reset_req;
   logic                 hold_active;
   logic                 hold_tick_seen;
   logic                 osc_wait;

   // Bus request qualifiers; one wait state, ack the cycle after request.
   // Masking with ack_o stops a request that is still held in the ack
   // cycle from being taken a second time.
   assign bus_req      = cyc_i & stb_i & ~ack_o;
   assign bus_wr       = bus_req & we_i;
   assign bus_idx      = adr_i[wdtf_pkg::ADDR_SHIFT +: wdtf_pkg::IDX_W];
   assign idx_in_range = (adr_i[31:wdtf_pkg::ADDR_SHIFT+wdtf_pkg::IDX_W]
                          == '0);
   assign wr_lane0     = bus_wr & sel_i[0] & idx_in_range;
   assign wr_byte      = dat_i[7:0];

   // Safety lock only counts when reset on underflow is enabled
   assign locked = rst_en & safety_en;

   // Write strobes; once locked the control and reload registers take one write only
   assign ctrl_wr   = wr_lane0 & (bus_idx == wdtf_pkg::CTRL_IDX)
                      & ~(locked & ctrl_written);
   assign reload_wr = wr_lane0 & (bus_idx == wdtf_pkg::RELOAD_IDX)
                      & ~(locked & reload_written);

   // Capture the configuration byte after reset release; safe until then
   // Both bits read as one during reset, so the strictest setting rules
   // until the real configuration is known
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rst_en     <= 1'b1;
         safety_en  <= 1'b1;
         cfg_loaded <= 1'b0;
      end else if (!cfg_loaded) begin
         rst_en     <= cfg_reset_enable_i;
         safety_en  <= cfg_safety_enable_i;
         cfg_loaded <= 1'b1;
      end
   end

   // Wishbone acknowledge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= bus_req;
      end
   end

   // Read data; unmapped addresses read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (bus_req && !we_i) begin
         dat_o <= 32'h0000_0000;
         if (idx_in_range) begin
            unique case (bus_idx)
               wdtf_pkg::CTRL_IDX: begin
                  dat_o[7:5] <= ctrl_shadow.prescaler_tap_select;
                  dat_o[2]   <= ctrl_shadow.run_control_bit | locked;
                  dat_o[1]   <= timeout_flag;
                  dat_o[0]   <= ctrl_shadow.clock_source_select | locked;
               end
               wdtf_pkg::RELOAD_IDX: begin
                  dat_o[COUNT_W-1:0] <= reload_shadow;
               end
               wdtf_pkg::MODE_IDX: begin
                  dat_o[wdtf_pkg::MODE_IRQ_EN] <= irq_enable;
                  dat_o[wdtf_pkg::MODE_RST_EN] <= rst_en;
                  dat_o[wdtf_pkg::MODE_SAFETY] <= safety_en;
               end
               default: begin
                  dat_o <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // Shadow control register; reset leaves timer running
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_shadow  <= wdtf_pkg::CTRL_RESET;
         ctrl_written <= 1'b0;
      end else if (ctrl_wr) begin
         ctrl_shadow  <= wdtf_pkg::wdtf_ctrl_t'(wr_byte);
         ctrl_shadow.reserved     <= 2'h0;
         ctrl_shadow.timeout_flag <= 1'b0;
         ctrl_written <= 1'b1;
      end
   end

   // Shadow reload register and interrupt enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reload_shadow  <= wdtf_pkg::RELOAD_RESET;
         reload_written <= 1'b0;
         irq_enable     <= 1'b0;
      end else begin
         if (reload_wr) begin
            reload_shadow  <= wr_byte[COUNT_W-1:0];
            reload_written <= 1'b1;
         end
         if (wr_lane0 && bus_idx == wdtf_pkg::MODE_IDX) begin
            irq_enable <= wr_byte[wdtf_pkg::MODE_IRQ_EN];
         end
      end
   end

   // Feed sequence checker; only writes disturb it, reads pass freely
   // A write with no low byte lane stores nothing but still counts as a
   // write, and writes elsewhere in the core arrive on other_sfr_write_i
   always_comb begin
      feed_ok  = 1'b0;
      feed_bad = 1'b0;
      if (bus_wr || other_sfr_write_i) begin
         if (wr_lane0 && bus_idx == wdtf_pkg::FEED1_IDX) begin
            if (feed_state == wdtf_pkg::FEED_ARMED) begin
               feed_bad = 1'b1;
            end else if (wr_byte != wdtf_pkg::FEED1_KEY) begin
               feed_bad = 1'b1;
            end
         end else if (wr_lane0 && bus_idx == wdtf_pkg::FEED2_IDX) begin
            if (feed_state != wdtf_pkg::FEED_ARMED
                || wr_byte != wdtf_pkg::FEED2_KEY) begin
               feed_bad = 1'b1;
            end else begin
               feed_ok = 1'b1;
            end
         end else if (feed_state != wdtf_pkg::FEED_IDLE) begin
            feed_bad = 1'b1;
         end
      end
   end

   // Feed state; a control write in watchdog mode demands a feed next
   always_ff @(posedge clk_i) begin
      if (rst_i || wd_reset_req) begin
         feed_state <= wdtf_pkg::FEED_IDLE;
      end else if (feed_bad || feed_ok) begin
         feed_state <= wdtf_pkg::FEED_IDLE;
      end else if (wr_lane0 && bus_idx == wdtf_pkg::FEED1_IDX) begin
         feed_state <= wdtf_pkg::FEED_ARMED;
      end else if (ctrl_wr && rst_en) begin
         feed_state <= wdtf_pkg::FEED_CTRL_WAIT;
      end
   end

   // Active control: on feed in watchdog mode, every cycle in timer mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_active <= wdtf_pkg::CTRL_RESET;
      end else if (!rst_en || feed_ok) begin
         ctrl_active <= ctrl_shadow;
      end
   end

   // Forced conditions under the safety lock
   assign eff_run = ctrl_active.run_control_bit | locked;
   assign eff_osc = ctrl_active.clock_source_select | locked;

   // Peripheral clock is half the core clock; source change waits a phase
   // Limitation: the peripheral clock is a fixed divide by two here; the
   // switch is only allowed on a phase boundary so no tick is cut in half
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pclk_phase <= 1'b0;
         src_osc    <= 1'b1;
      end else begin
         pclk_phase <= ~pclk_phase;
         if (pclk_phase) begin
            src_osc <= eff_osc;
         end
      end
   end

   assign wd_tick = src_osc ? wdosc_tick_i : pclk_phase;

   // Tap mask: prescaler wraps after 2^(5+tap) watchdog clocks
   // A mask compare keeps one comparator for all eight taps
   assign tap_mask = PRESC_W'((wdtf_pkg::TAP_BASE_ONE
                     << ctrl_active.prescaler_tap_select) - 13'h0001);

   // Underflow is one watchdog clock after the prescaler wraps with the count at zero
   // which gives the extra clock of the timeout law
   assign underflow = wd_tick & eff_run & underflow_pend;

   // Prescaler and down counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prescaler      <= '0;
         counter        <= wdtf_pkg::RELOAD_RESET[COUNT_W-1:0];
         underflow_pend <= 1'b0;
      end else if (feed_ok || wd_reset_req) begin
         prescaler      <= '0;
         counter        <= reload_shadow;
         underflow_pend <= 1'b0;
      end else if (wd_tick && eff_run) begin
         if (underflow_pend) begin
            underflow_pend <= 1'b0;
            prescaler      <= '0;
            counter        <= reload_shadow;
         end else if ((prescaler & tap_mask) == tap_mask) begin
            prescaler <= '0;
            if (counter == '0) begin
               underflow_pend <= 1'b1;
            end else begin
               counter <= counter - COUNT_W'(1);
            end
         end else begin
            prescaler <= prescaler + PRESC_W'(1);
         end
      end
   end

   // Timeout flag: underflow sets it and beats a same-cycle clear
   // Losing the set would hide a timeout that software never saw
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timeout_flag <= 1'b0;
      end else if (underflow) begin
         timeout_flag <= 1'b1;
      end else if (feed_ok && rst_en) begin
         timeout_flag <= 1'b0;
      end else if (ctrl_wr && !wr_byte[1]) begin
         timeout_flag <= 1'b0;
      end
   end

   // Timer-mode interrupt request
   assign timeout_irq_o = timeout_flag & irq_enable & ~rst_en;

   // Reset cause: underflow or bad feed, only with reset enabled
   assign wd_reset_req = rst_en & (underflow | feed_bad);

   // Reset stretch: hold across one full selected watchdog clock
   // Two ticks are awaited: the request may land just before a tick, and
   // ending on that tick would give only a fraction of a watchdog clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_active    <= 1'b0;
         hold_tick_seen <= 1'b0;
      end else if (wd_reset_req) begin
         hold_active    <= 1'b1;
         hold_tick_seen <= 1'b0;
      end else if (hold_active && wd_tick) begin
         hold_tick_seen <= 1'b1;
         if (hold_tick_seen) begin
            hold_active <= 1'b0;
         end
      end
   end

   // Power-down recovery: keep reset until the oscillator is stable
   // Setting wins over a clear in the same cycle, so a stable oscillator
   // cannot swallow a fresh request made while powered down
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_wait <= 1'b0;
      end else if (wd_reset_req && power_down_i) begin
         osc_wait <= 1'b1;
      end else if (osc_stable_i) begin
         osc_wait <= 1'b0;
      end
   end

   // Reset outputs registered so they never glitch
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wdt_reset_o   <= 1'b0;
         osc_restart_o <= 1'b0;
      end else begin
         wdt_reset_o   <= wd_reset_req | hold_active
                          | (osc_wait & ~osc_stable_i);
         osc_restart_o <= (wd_reset_req & power_down_i)
                          | (osc_wait & ~osc_stable_i);
      end
   end

endmodule

// ===== dv/wdtf_checker.sv
// Checker: bus handshake and system output rules of the watchdog
`timescale 1ns/10ps
module wdtf_checker #(
   parameter int PRESC_W = 13,
   parameter int COUNT_W = 8
) (
   // Ports watched on the design top
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [31:0] adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        cfg_reset_enable_i,
   input wire logic        osc_stable_i,
   input wire logic        wdt_reset_o,
   input wire logic        osc_restart_o,
   input wire logic        timeout_irq_o
);
   logic rst_q;
   logic wd_mode;
   logic wr_take;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Mode as the design sees it: watchdog until the config is caught
   always_ff @(posedge clk_i) rst_q <= rst_i;
   always_ff @(posedge clk_i)
      wd_mode <= rst_i ? 1'b1 : (rst_q ? cfg_reset_enable_i : wd_mode);
   // Write taken this edge in watchdog mode; low byte lane only
   assign wr_take = cyc_i && stb_i && !ack_o && we_i && sel_i[0]
                    && adr_i[31:10] == 22'h0 && wd_mode;
   ack_once_a:
      assert property (ack_o |=> !ack_o) else $error("ack too long");
   ack_due_a:
      assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack missing");
   read_lane_a:
      assert property (ack_o |-> dat_o[31:8] == 24'h0)
      else $error("read upper bits set");
   bad_first_a:
      assert property (wr_take && adr_i[9:2] == wdtf_pkg::FEED1_IDX &&
         dat_i[7:0] != wdtf_pkg::FEED1_KEY |-> ##[1:2] wdt_reset_o)
      else $error("bad first feed gave no reset");
   bad_second_a:
      assert property (wr_take && adr_i[9:2] == wdtf_pkg::FEED2_IDX &&
         dat_i[7:0] != wdtf_pkg::FEED2_KEY |-> ##[1:2] wdt_reset_o)
      else $error("bad second feed gave no reset");
   timer_quiet_a:
      assert property (!wd_mode |-> !wdt_reset_o)
      else $error("reset in timer mode");
   irq_gate_a:
      assert property (wd_mode |-> !timeout_irq_o)
      else $error("irq in watchdog mode");
   rst_hold_a:
      assert property ($rose(wdt_reset_o) |=> wdt_reset_o)
      else $error("reset pulse too short");
   restart_hold_a:
      assert property (osc_restart_o && !osc_stable_i |=> osc_restart_o)
      else $error("restart dropped early");
   // Main scenarios reached
   cover property ($rose(wdt_reset_o));
   cover property ($rose(timeout_irq_o));
   cover property ($rose(osc_restart_o));
endmodule
bind wdtf_top wdtf_checker #(.PRESC_W(PRESC_W), .COUNT_W(COUNT_W))
   chk (.*);

// ===== dv/tb_top.sv
// Testbench: register-level scenarios for the watchdog timer
`timescale 1ns/10ps
module tb_top;
   logic        clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, we_i = 1'b0;
   logic        ack_o, wdt_reset_o, osc_restart_o, timeout_irq_o;
   logic        cfg_reset_enable_i = 1'b1, cfg_safety_enable_i = 1'b0;
   logic        wdosc_tick_i = 1'b0, other_sfr_write_i = 1'b0;
   logic        power_down_i = 1'b0, osc_stable_i = 1'b0;
   logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o, q;
   logic [3:0]  sel_i = 4'h1;
   int          miscompares, cmp_count, n, k, cyc_n;
   wdtf_top dut (.cyc_i(req), .stb_i(req), .*);
   // Core clock, 4 ns period
   initial forever #2 clk_i = ~clk_i;
   // Hang guard: the whole run needs far fewer cycles
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000) begin
         miscompares++;
         results();
      end
   end
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // 0 system reset, 1 interrupt, 2 oscillator restart
   function automatic logic pick(input int s);
      return (s == 0) ? wdt_reset_o : (s == 1) ? timeout_irq_o
                                                 : osc_restart_o;
   endfunction
   task automatic chk1(input int s, input logic v);
      check({31'h0, pick(s)}, {31'h0, v});
   endtask
   // One classic cycle, released only at the edge that samples ack
   task automatic wb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
      @(posedge clk_i);
      req <= 1'b1;
      we_i <= w;
      adr_i <= {22'h0, idx, 2'b00};
      dat_i <= {24'h0, d};
      // Ack is looked at on rising edges only; the hang guard ends a stall
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      q = dat_o;
      req <= 1'b0;
      if (!w) check(q, {24'h0, d});
   endtask
   task automatic feed();
      wb(1'b1, wdtf_pkg::FEED1_IDX, wdtf_pkg::FEED1_KEY);
      wb(1'b1, wdtf_pkg::FEED2_IDX, wdtf_pkg::FEED2_KEY);
   endtask
   // Oscillator ticks one core cycle wide; ends settled on a low phase
   task automatic ticks(input int cnt);
      repeat (cnt) begin
         @(posedge clk_i);
         wdosc_tick_i <= 1'b1;
         @(posedge clk_i);
         wdosc_tick_i <= 1'b0;
         @(posedge clk_i);
         @(negedge clk_i);
      end
   endtask
   task automatic wait_hi(input int s, input int lim);
      n = 0;
      while (pick(s) !== 1'b1 && n < lim) begin
         @(negedge clk_i);
         n++;
      end
   endtask
   // A broken feed must raise the reset; later ticks let it fall
   task automatic wr_bad(input logic [7:0] idx, input logic [7:0] d);
      wb(1'b1, idx, d);
      wait_hi(0, 4);
      chk1(0, 1'b1);
      ticks(3);
      chk1(0, 1'b0);
   endtask
   task automatic reset_dut(input logic r, input logic s);
      @(posedge clk_i);
      rst_i <= 1'b1;
      cfg_reset_enable_i <= r;
      cfg_safety_enable_i <= s;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   initial begin
      // Only the ticks of wr_bad here, far too few for the counter to expire on its own
      reset_dut(1'b1, 1'b0);
      wb(1'b0, wdtf_pkg::CTRL_IDX, 8'he5);
      wb(1'b0, wdtf_pkg::MODE_IDX, 8'h02);
      wb(1'b0, wdtf_pkg::RELOAD_IDX, 8'hff);
      wb(1'b0, 8'h10, 8'h00);
      wr_bad(wdtf_pkg::FEED1_IDX, 8'h00);
      wr_bad(wdtf_pkg::FEED2_IDX, wdtf_pkg::FEED2_KEY);
      wb(1'b1, wdtf_pkg::FEED1_IDX, wdtf_pkg::FEED1_KEY);
      wr_bad(wdtf_pkg::FEED2_IDX, 8'h00);
      wb(1'b1, wdtf_pkg::FEED1_IDX, wdtf_pkg::FEED1_KEY);
      other_sfr_write_i <= 1'b1;
      @(posedge clk_i);
      other_sfr_write_i <= 1'b0;
      wr_bad(wdtf_pkg::FEED2_IDX, wdtf_pkg::FEED2_KEY);
      wb(1'b1, wdtf_pkg::CTRL_IDX, 8'h05);
      wr_bad(wdtf_pkg::RELOAD_IDX, 8'h00);
      $display("test reset and broken feeds done");
      // Shortest timeout counted in ticks, with a read inside the feed
      wb(1'b1, wdtf_pkg::RELOAD_IDX, 8'h00);
      wb(1'b1, wdtf_pkg::CTRL_IDX, 8'h05);
      wb(1'b1, wdtf_pkg::FEED1_IDX, wdtf_pkg::FEED1_KEY);
      wb(1'b0, wdtf_pkg::CTRL_IDX, 8'h05);
      wb(1'b1, wdtf_pkg::FEED2_IDX, wdtf_pkg::FEED2_KEY);
      chk1(0, 1'b0);
      for (k = 1; k < 40 && wdt_reset_o !== 1'b1; k++) begin
         ticks(1);
      end
      check(k, 34);
      repeat (3) @(negedge clk_i);
      chk1(0, 1'b1);
      ticks(2);
      chk1(0, 1'b0);
      wb(1'b0, wdtf_pkg::CTRL_IDX, 8'h07);
      feed();
      wb(1'b0, wdtf_pkg::CTRL_IDX, 8'h05);
      power_down_i <= 1'b1;
      wb(1'b1, wdtf_pkg::FEED1_IDX, 8'h3c);
      ticks(3);
      chk1(2, 1'b1);
      chk1(0, 1'b1);
      @(posedge clk_i);
      osc_stable_i <= 1'b1;
      ticks(3);
      chk1(2, 1'b0);
      chk1(0, 1'b0);
      $display("test timeout and power-down done");
      // Timer mode: interrupt instead of reset, control taken at once
      reset_dut(1'b0, 1'b1);
      wb(1'b0, wdtf_pkg::MODE_IDX, 8'h04);
      wb(1'b1, wdtf_pkg::MODE_IDX, 8'h01);
      wb(1'b1, wdtf_pkg::RELOAD_IDX, 8'h00);
      wb(1'b1, wdtf_pkg::CTRL_IDX, 8'h04);
      feed();
      wait_hi(1, 100);
      check({31'h0, n >= 60 && n <= 72}, 32'h1);
      chk1(0, 1'b0);
      wb(1'b0, wdtf_pkg::CTRL_IDX, 8'h06);
      wb(1'b1, wdtf_pkg::CTRL_IDX, 8'h04);
      chk1(1, 1'b0);
      wb(1'b1, wdtf_pkg::CTRL_IDX, 8'h00);
      repeat (150) @(negedge clk_i);
      chk1(1, 1'b0);
      $display("test timer mode done");
      // Safety lock: source and run forced, one write each
      reset_dut(1'b1, 1'b1);
      wb(1'b0, wdtf_pkg::MODE_IDX, 8'h06);
      wb(1'b1, wdtf_pkg::CTRL_IDX, 8'h00);
      feed();
      wb(1'b0, wdtf_pkg::CTRL_IDX, 8'h05);
      wb(1'b1, wdtf_pkg::CTRL_IDX, 8'h40);
      feed();
      wb(1'b0, wdtf_pkg::CTRL_IDX, 8'h05);
      wb(1'b1, wdtf_pkg::RELOAD_IDX, 8'h03);
      wb(1'b1, wdtf_pkg::RELOAD_IDX, 8'h07);
      wb(1'b0, wdtf_pkg::RELOAD_IDX, 8'h03);
      chk1(0, 1'b0);
      $display("test safety lock done");
      results();
   end
endmodule
